/* File: core/lpcfp_buf2.sv */
// Purpose: Two-entry byte buffer with valid and ready on both sides
// Assumes: Same clock on both sides
// Notes:   Outputs and in_ready all come from flops; in_ready drops once the tail entry is full
`default_nettype none
module lpcfp_buf2 (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire lpcfp_pkg::lpcfp_byte_t in_data,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  output lpcfp_pkg::lpcfp_byte_t    out_data,
  output logic                      out_valid,
  input  wire logic                 out_ready
);
  import lpcfp_pkg::*;

  lpcfp_byte_t head_r, head_nxt, tail_r, tail_nxt;
  logic        hv_r, hv_nxt, tv_r, tv_nxt;
  logic        push, pop;

  always_comb begin
    push     = in_valid & ~tv_r;
    pop      = hv_r & out_ready;
    head_nxt = head_r;
    tail_nxt = tail_r;
    hv_nxt   = hv_r;
    tv_nxt   = tv_r;
    if (pop) begin
      if (tv_r) begin
        head_nxt = tail_r;
        tv_nxt   = 1'b0;
      end else begin
        head_nxt = in_data;
        hv_nxt   = push;
      end
    end else if (push) begin
      if (!hv_r) begin
        head_nxt = in_data;
        hv_nxt   = 1'b1;
      end else begin
        tail_nxt = in_data;
        tv_nxt   = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      head_r <= 8'h00;
      tail_r <= 8'h00;
      hv_r   <= 1'b0;
      tv_r   <= 1'b0;
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      hv_r   <= hv_nxt;
      tv_r   <= tv_nxt;
    end
  end

  assign in_ready  = ~tv_r;
  assign out_data  = head_r;
  assign out_valid = hv_r;
endmodule : lpcfp_buf2
`default_nettype wire

/* File: core/lpcfp_parser.sv */
// Purpose: Parses local parameter command frames, applies or queries parameters, builds responses
// Assumes: Byte stream from logic on CLOCK; temperature arrives from outside and is synchronised
// Notes:   Escaped framing is not supported, so the escape option only accepts 0 or 1
//
// How it works
// - A frame begins when the start delimiter byte is seen while idle.
// - The two bytes after the delimiter give the count of bytes between length and checksum.
// - Only frame type 0x08 is acted upon; other types are dropped.
// - A correlation tag of zero suppresses the response frame.
// - Body bytes two and three name the parameter command.
// - Parameter bytes after the command name are written to the parameter at once.
// - A frame with no parameter bytes is a query and returns the current value.
// - The checksum is 0xff minus the low byte of the sum of all body bytes.
// - The response has type 0x88 and repeats the request's tag.
// - A set answers with a status telling whether the change was accepted.
// - Bytes are taken literally; a delimiter value inside a frame is data.
`default_nettype none
module lpcfp_parser (
  input  wire logic                   CLOCK,
  input  wire logic                   RST,
  input  wire lpcfp_pkg::lpcfp_byte_t RX_DATA,
  input  wire logic                   RX_VALID,
  output logic                        RX_READY,
  input  wire logic [15:0]            TEMP_SENSE,
  output lpcfp_pkg::lpcfp_byte_t      TX_DATA,
  output logic                        TX_VALID,
  input  wire logic                   TX_READY,
  output logic [7:0]                  API_ESCAPE_OPTION,
  output logic [31:0]                 NODE_LABEL,
  output logic [2:0]                  NODE_LABEL_LEN,
  output logic                        FRAME_ERROR
);
  import lpcfp_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_LEN_HI, S_LEN_LO, S_BODY, S_CSUM, S_EXEC, S_RESP} lpcfp_state_e;

  function automatic lpcfp_byte_t csum_add(input lpcfp_byte_t a, input lpcfp_byte_t b);
    csum_add = a + b;
  endfunction : csum_add

  function automatic lpcfp_byte_t data_byte(input logic [31:0] d, input logic [2:0] n, input logic [3:0] k);
    logic [4:0] sh;
    sh = 5'({n - 3'h1 - k[2:0], 3'h0});
    data_byte = 8'(d >> sh);
  endfunction : data_byte

  lpcfp_state_e state_r, state_nxt;
  logic [15:0]  len_r, len_nxt, cnt_r, cnt_nxt, pcnt_r, pcnt_nxt;
  lpcfp_byte_t  sum_r, sum_nxt, tsum_r, tsum_nxt;
  lpcfp_hdr_s   hdr_r, hdr_nxt;
  logic [31:0]  pbuf_r, pbuf_nxt;
  lpcfp_rsp_s   rsp_r, rsp_nxt;
  logic [3:0]   ridx_r, ridx_nxt;
  logic         rx_ready_r, rx_ready_nxt, err_r, err_nxt;
  logic [7:0]   escape_r, escape_nxt;
  logic [31:0]  label_r, label_nxt;
  logic [2:0]   label_len_r, label_len_nxt;
  logic [15:0]  temp_m_r, temp_s_r, temp_p_r, temp_h_r;
  logic         rx_take, csum_ok;
  lpcfp_byte_t  push_data;
  logic         push_valid, push_ready, push_last;
  logic         is_set;

  // Sensor value comes from outside this clock
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      temp_m_r <= 16'h0000;
      temp_s_r <= 16'h0000;
      temp_p_r <= 16'h0000;
      temp_h_r <= 16'h0000;
    end else begin
      temp_m_r <= TEMP_SENSE;
      temp_s_r <= temp_m_r;
      temp_p_r <= temp_s_r;
      // Bits may land on different edges, so a word is kept only once two samples agree
      temp_h_r <= temp_s_r == temp_p_r ? temp_s_r : temp_h_r;
    end
  end

  assign rx_take = RX_VALID & rx_ready_r;
  assign csum_ok = csum_add(sum_r, RX_DATA) == CSUM_GOOD;
  assign is_set  = pcnt_r != 16'h0000;

  // Response byte chosen by position
  always_comb begin
    push_data = 8'h00;
    push_last = 1'b0;
    unique case (ridx_r)
      RSP_DELIM:  push_data = START_DELIM;
      RSP_LEN_HI: push_data = 8'h00;
      RSP_LEN_LO: push_data = RSP_FIXED_LEN + {5'h00, rsp_r.dlen};
      RSP_TYPE:   push_data = TYPE_LOCAL_RSP;
      RSP_ID:     push_data = hdr_r.fid;
      RSP_CMD_HI: push_data = hdr_r.cmd[15:8];
      RSP_CMD_LO: push_data = hdr_r.cmd[7:0];
      RSP_STATUS: push_data = rsp_r.status;
      default: begin
        if (ridx_r - RSP_DATA < {1'b0, rsp_r.dlen}) begin
          push_data = data_byte(rsp_r.data, rsp_r.dlen, ridx_r - RSP_DATA);
        end else begin
          push_data = CSUM_GOOD - tsum_r;
          push_last = 1'b1;
        end
      end
    endcase
  end

  assign push_valid = state_r == S_RESP;

  always_comb begin
    state_nxt     = state_r;
    len_nxt       = len_r;
    cnt_nxt       = cnt_r;
    pcnt_nxt      = pcnt_r;
    sum_nxt       = sum_r;
    tsum_nxt      = tsum_r;
    hdr_nxt       = hdr_r;
    pbuf_nxt      = pbuf_r;
    rsp_nxt       = rsp_r;
    ridx_nxt      = ridx_r;
    err_nxt       = 1'b0;
    escape_nxt    = escape_r;
    label_nxt     = label_r;
    label_len_nxt = label_len_r;
    unique case (state_r)
      S_IDLE: begin
        if (rx_take && RX_DATA == START_DELIM) begin
          state_nxt = S_LEN_HI;
        end
      end
      S_LEN_HI: begin
        if (rx_take) begin
          len_nxt[15:8] = RX_DATA;
          state_nxt     = S_LEN_LO;
        end
      end
      S_LEN_LO: begin
        if (rx_take) begin
          len_nxt[7:0] = RX_DATA;
          cnt_nxt      = 16'h0000;
          pcnt_nxt     = 16'h0000;
          sum_nxt      = 8'h00;
          pbuf_nxt     = 32'h0000_0000;
          state_nxt    = {len_r[15:8], RX_DATA} == 16'h0000 ? S_CSUM : S_BODY;
        end
      end
      S_BODY: begin
        // A delimiter value here is ordinary data; no resync on it
        if (rx_take) begin
          unique case (cnt_r)
            BODY_TYPE:   hdr_nxt.ftype    = RX_DATA;
            BODY_ID:     hdr_nxt.fid      = RX_DATA;
            BODY_CMD_HI: hdr_nxt.cmd[15:8] = RX_DATA;
            BODY_CMD_LO: hdr_nxt.cmd[7:0]  = RX_DATA;
            default: begin
              pcnt_nxt = pcnt_r + 16'h0001;
              pbuf_nxt = {pbuf_r[23:0], RX_DATA};
            end
          endcase
          sum_nxt = csum_add(sum_r, RX_DATA);
          cnt_nxt = cnt_r + 16'h0001;
          if (cnt_r + 16'h0001 == len_r) begin
            state_nxt = S_CSUM;
          end
        end
      end
      S_CSUM: begin
        if (rx_take) begin
          if (!csum_ok || len_r < BODY_MIN_LEN) begin
            err_nxt   = 1'b1;
            state_nxt = S_IDLE;
          end else if (hdr_r.ftype != TYPE_LOCAL_CMD) begin
            state_nxt = S_IDLE;
          end else begin
            state_nxt = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        rsp_nxt.status = ST_OK;
        rsp_nxt.data   = 32'h0000_0000;
        rsp_nxt.dlen   = 3'h0;
        unique case (hdr_r.cmd)
          CMD_NODE_LABEL: begin
            if (!is_set) begin
              rsp_nxt.data = label_r;
              rsp_nxt.dlen = label_len_r;
            end else if (pcnt_r <= PARAM_MAX) begin
              label_nxt     = pbuf_r;
              label_len_nxt = 3'(pcnt_r);
            end else begin
              rsp_nxt.status = ST_BAD_PARAM;
            end
          end
          CMD_TEMP_QUERY: begin
            if (!is_set) begin
              rsp_nxt.data = {16'h0000, temp_h_r};
              rsp_nxt.dlen = 3'h2;
            end else begin
              rsp_nxt.status = ST_ERROR;
            end
          end
          CMD_ESCAPE_OPT: begin
            if (!is_set) begin
              rsp_nxt.data = {24'h000000, escape_r};
              rsp_nxt.dlen = 3'h1;
            end else if (pcnt_r == 16'h0001 && pbuf_r[7:0] <= ESCAPE_MAX_OK) begin
              escape_nxt = pbuf_r[7:0];
            end else begin
              rsp_nxt.status = ST_BAD_PARAM;
            end
          end
          default: rsp_nxt.status = ST_BAD_CMD;
        endcase
        ridx_nxt  = RSP_DELIM;
        tsum_nxt  = 8'h00;
        state_nxt = hdr_r.fid == NO_RESPONSE_ID ? S_IDLE : S_RESP;
      end
      S_RESP: begin
        // Waits on the buffer, so a stalled receiver holds this state
        if (push_ready) begin
          if (ridx_r >= RSP_TYPE) begin
            tsum_nxt = csum_add(tsum_r, push_data);
          end
          ridx_nxt = ridx_r + 4'h1;
          if (push_last) begin
            state_nxt = S_IDLE;
          end
        end
      end
    endcase
    rx_ready_nxt = state_nxt != S_EXEC && state_nxt != S_RESP;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_r     <= S_IDLE;
      len_r       <= 16'h0000;
      cnt_r       <= 16'h0000;
      pcnt_r      <= 16'h0000;
      sum_r       <= 8'h00;
      tsum_r      <= 8'h00;
      hdr_r       <= '0;
      pbuf_r      <= 32'h0000_0000;
      rsp_r       <= '0;
      ridx_r      <= 4'h0;
      rx_ready_r  <= 1'b0;
      err_r       <= 1'b0;
      escape_r    <= ESCAPE_RST;
      label_r     <= LABEL_RST;
      label_len_r <= LABEL_LEN_RST;
    end else begin
      state_r     <= state_nxt;
      len_r       <= len_nxt;
      cnt_r       <= cnt_nxt;
      pcnt_r      <= pcnt_nxt;
      sum_r       <= sum_nxt;
      tsum_r      <= tsum_nxt;
      hdr_r       <= hdr_nxt;
      pbuf_r      <= pbuf_nxt;
      rsp_r       <= rsp_nxt;
      ridx_r      <= ridx_nxt;
      rx_ready_r  <= rx_ready_nxt;
      err_r       <= err_nxt;
      escape_r    <= escape_nxt;
      label_r     <= label_nxt;
      label_len_r <= label_len_nxt;
    end
  end

  lpcfp_buf2 u_txbuf (
    .clk       (CLOCK),
    .rst       (RST),
    .in_data   (push_data),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (TX_DATA),
    .out_valid (TX_VALID),
    .out_ready (TX_READY)
  );

  assign RX_READY          = rx_ready_r;
  assign FRAME_ERROR       = err_r;
  assign API_ESCAPE_OPTION = escape_r;
  assign NODE_LABEL        = label_r;
  assign NODE_LABEL_LEN    = label_len_r;

  a_start_opens: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == S_IDLE && rx_take && RX_DATA == START_DELIM) |=> state_r == S_LEN_HI)
    else $error("delimiter did not open a frame");
  a_len_high_first: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == S_LEN_HI && rx_take) ##1 (state_r == S_LEN_LO && rx_take)
      |=> len_r == {$past(RX_DATA, 2), $past(RX_DATA)})
    else $error("length not assembled high byte first");
  a_type_gate: assert property (@(posedge CLOCK) disable iff (RST)
    state_r == S_EXEC |-> hdr_r.ftype == TYPE_LOCAL_CMD)
    else $error("non local command type executed");
  a_tag_zero_quiet: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == S_EXEC && hdr_r.fid == NO_RESPONSE_ID) |=> state_r == S_IDLE && !push_valid)
    else $error("response started for zero tag");
  a_cmd_capture: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == S_BODY && rx_take && cnt_r == BODY_CMD_LO) |=> hdr_r.cmd[7:0] == $past(RX_DATA))
    else $error("command low character not captured");
  a_set_now: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == S_EXEC && hdr_r.cmd == CMD_ESCAPE_OPT && pcnt_r == 16'h0001 && pbuf_r[7:0] <= ESCAPE_MAX_OK)
      |=> API_ESCAPE_OPTION == $past(pbuf_r[7:0]))
    else $error("escape option not applied at once");
  a_query_temp: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == S_EXEC && !is_set && hdr_r.cmd == CMD_TEMP_QUERY)
      |=> rsp_r.data[15:0] == $past(temp_h_r) && rsp_r.dlen == 3'h2)
    else $error("temperature query returned wrong value");
  a_bad_sum_drop: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == S_CSUM && rx_take && !csum_ok) |=> state_r == S_IDLE && FRAME_ERROR ##1 !FRAME_ERROR)
    else $error("bad checksum frame not dropped");
  a_rsp_tag: assert property (@(posedge CLOCK) disable iff (RST)
    (push_valid && push_ready && ridx_r == RSP_TYPE) |-> push_data == TYPE_LOCAL_RSP
      ##1 (ridx_r == RSP_ID && push_data == hdr_r.fid))
    else $error("response type or tag wrong");
  a_ro_refused: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == S_EXEC && is_set && hdr_r.cmd == CMD_TEMP_QUERY) |=> rsp_r.status == ST_ERROR)
    else $error("read only set not refused");
  a_delim_is_data: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == S_BODY && rx_take && RX_DATA == START_DELIM) |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("delimiter value inside body not counted");
endmodule : lpcfp_parser
`default_nettype wire

/* File: core/lpcfp_pkg.sv */
// Purpose: Shared constants and carriers for the local parameter command frame parser
// Assumes: Unescaped byte framing, one clock domain
// Notes:   Command codes are the two ASCII characters of each command, high character first
`default_nettype none
package lpcfp_pkg;
  localparam logic [7:0]  START_DELIM    = 8'h7e;
  localparam logic [7:0]  TYPE_LOCAL_CMD = 8'h08;
  localparam logic [7:0]  TYPE_LOCAL_RSP = 8'h88;
  localparam logic [7:0]  CSUM_GOOD      = 8'hff;
  localparam logic [7:0]  NO_RESPONSE_ID = 8'h00;
  localparam logic [15:0] CMD_NODE_LABEL = 16'h4e49;
  localparam logic [15:0] CMD_TEMP_QUERY = 16'h5450;
  localparam logic [15:0] CMD_ESCAPE_OPT = 16'h4150;
  localparam logic [7:0]  ST_OK          = 8'h00;
  localparam logic [7:0]  ST_ERROR       = 8'h01;
  localparam logic [7:0]  ST_BAD_CMD     = 8'h02;
  localparam logic [7:0]  ST_BAD_PARAM   = 8'h03;
  localparam logic [7:0]  ESCAPE_MAX_OK  = 8'h01;
  // Body offsets, counted from the frame type byte
  localparam logic [15:0] BODY_TYPE      = 16'h0000;
  localparam logic [15:0] BODY_ID        = 16'h0001;
  localparam logic [15:0] BODY_CMD_HI    = 16'h0002;
  localparam logic [15:0] BODY_CMD_LO    = 16'h0003;
  localparam logic [15:0] BODY_MIN_LEN   = 16'h0004;
  localparam logic [15:0] PARAM_MAX      = 16'h0004;
  // Response byte positions
  localparam logic [3:0]  RSP_DELIM      = 4'h0;
  localparam logic [3:0]  RSP_LEN_HI     = 4'h1;
  localparam logic [3:0]  RSP_LEN_LO     = 4'h2;
  localparam logic [3:0]  RSP_TYPE       = 4'h3;
  localparam logic [3:0]  RSP_ID         = 4'h4;
  localparam logic [3:0]  RSP_CMD_HI     = 4'h5;
  localparam logic [3:0]  RSP_CMD_LO     = 4'h6;
  localparam logic [3:0]  RSP_STATUS     = 4'h7;
  localparam logic [3:0]  RSP_DATA       = 4'h8;
  localparam logic [7:0]  RSP_FIXED_LEN  = 8'h05;
  // Values after reset
  localparam logic [7:0]  ESCAPE_RST     = 8'h01;
  localparam logic [31:0] LABEL_RST      = 32'h0000_0000;
  localparam logic [2:0]  LABEL_LEN_RST  = 3'h0;

  typedef logic [7:0] lpcfp_byte_t;

  typedef struct packed {
    logic [7:0]  ftype;
    logic [7:0]  fid;
    logic [15:0] cmd;
  } lpcfp_hdr_s;

  typedef struct packed {
    logic [7:0]  status;
    logic [31:0] data;
    logic [2:0]  dlen;
  } lpcfp_rsp_s;
endpackage : lpcfp_pkg
`default_nettype wire

/* File: verif/lpcfp_host.sv */
// Purpose: Host model that sends command frames and collects response bytes
// Assumes: Drives at the falling edge; the response side may stall
// Notes:   Request lines released by send_frame show the inverse of the last byte, never a stale copy
`default_nettype none
module lpcfp_host (
  input  wire logic                   clk,
  output lpcfp_pkg::lpcfp_byte_t      rx_data,
  output logic                        rx_valid,
  input  wire logic                   rx_ready,
  input  wire lpcfp_pkg::lpcfp_byte_t tx_data,
  input  wire logic                   tx_valid,
  output logic                        tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import lpcfp_pkg::*;
  lpcfp_byte_t got_q[$];
  logic        hold = 1'b0;
  logic        slow = 1'b0;
  logic [1:0]  pace = 2'h0;
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // Slow mode accepts one byte in four, so the buffer fills behind it
  always @(negedge clk) begin
    pace     <= pace + 2'h1;
    tx_ready <= !hold && (!slow || pace == 2'h0);
  end
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got_q.push_back(tx_data);
    end
  end
  task automatic put_byte(input lpcfp_byte_t b);
    logic taken;
    rx_data  = b;
    rx_valid = 1'b1;
    taken    = 1'b0;
    while (!taken) begin
      taken = rx_ready;
      @(negedge clk);
    end
  endtask : put_byte
  task automatic send_frame(input lpcfp_byte_t ft, input lpcfp_byte_t fid, input logic [15:0] cmd,
                            input lpcfp_byte_t prm[$], input lpcfp_byte_t cerr);
    lpcfp_byte_t body[$];
    lpcfp_byte_t sum;
    body = {ft, fid, cmd[15:8], cmd[7:0]};
    body = {body, prm};
    sum  = 8'h00;
    foreach (body[i]) sum += body[i];
    @(negedge clk);
    put_byte(START_DELIM);
    put_byte(8'(body.size() >> 8));
    put_byte(8'(body.size()));
    foreach (body[i]) put_byte(body[i]);
    put_byte((CSUM_GOOD - sum) ^ cerr);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask : send_frame
endmodule : lpcfp_host
`default_nettype wire

/* File: verif/lpcfp_parser_tb.sv */
// Purpose: Self-checking bench for the command frame parser against a queue model
// Assumes: Host model drives requests; responses compared byte by byte
// Notes:   Loop label parameter bytes, the sensor word and the loop tags come from an xorshift generator
`default_nettype none
module lpcfp_parser_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lpcfp_pkg::*;
  logic        CLOCK;
  logic        RST;
  logic [15:0] TEMP_SENSE;
  lpcfp_byte_t rx_data, tx_data;
  logic        rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]  esc_out;
  logic [31:0] lab_out;
  logic [2:0]  len_out;
  logic        ferr;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          err_cnt = 0;
  int          err_exp = 0;
  logic [31:0] seed = 32'd71090;
  logic [7:0]  m_esc = ESCAPE_RST;
  logic [31:0] m_lab = LABEL_RST;
  logic [2:0]  m_len = LABEL_LEN_RST;
  logic [15:0] temp;
  lpcfp_byte_t exp_q[$], prm[$];

  lpcfp_parser i_lpcfp_parser (.CLOCK(CLOCK), .RST(RST), .RX_DATA(rx_data), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .TEMP_SENSE(TEMP_SENSE), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .API_ESCAPE_OPTION(esc_out), .NODE_LABEL(lab_out),
    .NODE_LABEL_LEN(len_out), .FRAME_ERROR(ferr));
  lpcfp_host i_lpcfp_host (.clk(CLOCK), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    if (ferr === 1'b1) err_cnt++;
  end

  function automatic lpcfp_byte_t rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic note(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : note
  task automatic expect_rsp(input lpcfp_byte_t tag, input logic [15:0] cmd, input lpcfp_byte_t st,
                            input logic [31:0] d, input int n);
    lpcfp_byte_t r[$];
    lpcfp_byte_t s;
    r = {TYPE_LOCAL_RSP, tag, cmd[15:8], cmd[7:0], st};
    for (int i = n - 1; i >= 0; i--) r.push_back(d[8*i +: 8]);
    s = 8'h00;
    foreach (r[i]) s += r[i];
    exp_q = {exp_q, START_DELIM, 8'h00, 8'(5 + n), r, 8'hff - s};
  endtask : expect_rsp
  // Model first, then the frame, so back-to-back frames see the model in order
  task automatic run(input lpcfp_byte_t ft, input lpcfp_byte_t tag, input logic [15:0] cmd,
                     input lpcfp_byte_t cerr);
    lpcfp_byte_t st;
    logic [31:0] d;
    int          n;
    logic        ok;
    ok = (ft == TYPE_LOCAL_CMD) && (cerr == 8'h00);
    n  = 0;
    d  = 32'h0;
    st = ST_BAD_CMD;
    if (cmd == CMD_TEMP_QUERY) begin
      d  = {16'h0, temp};
      n  = prm.size() == 0 ? 2 : 0;
      st = prm.size() == 0 ? ST_OK : ST_ERROR;
    end else if (cmd == CMD_NODE_LABEL) begin
      d  = m_lab;
      n  = prm.size() == 0 ? int'(m_len) : 0;
      st = prm.size() > 4 ? ST_BAD_PARAM : ST_OK;
      if (ok && prm.size() > 0 && prm.size() <= 4) begin
        m_len = 3'(prm.size());
        m_lab = 32'h0;
        foreach (prm[i]) m_lab = {m_lab[23:0], prm[i]};
      end
    end else if (cmd == CMD_ESCAPE_OPT) begin
      d  = {24'h0, m_esc};
      n  = prm.size() == 0 ? 1 : 0;
      st = (prm.size() > 1 || (prm.size() == 1 && prm[0] > ESCAPE_MAX_OK)) ? ST_BAD_PARAM : ST_OK;
      if (ok && prm.size() == 1 && st == ST_OK) m_esc = prm[0];
    end
    if (cerr != 8'h00) err_exp++;
    if (ok && tag != NO_RESPONSE_ID) expect_rsp(tag, cmd, st, d, n);
    i_lpcfp_host.send_frame(ft, tag, cmd, prm, cerr);
  endtask : run
  task automatic settle();
    int w;
    w = 0;
    while (i_lpcfp_host.got_q.size() < exp_q.size() && w < 400) begin
      @(negedge CLOCK);
      w++;
    end
    repeat (8) @(negedge CLOCK);
    note(i_lpcfp_host.got_q.size() == exp_q.size(), "response byte count");
    foreach (exp_q[i]) begin
      if (i < i_lpcfp_host.got_q.size()) note(i_lpcfp_host.got_q[i] === exp_q[i], "response byte");
    end
    note(esc_out === m_esc, "escape option");
    note(lab_out === m_lab, "node label");
    note(len_out === m_len, "node label length");
    note(err_cnt == err_exp, "frame error count");
    exp_q = {};
    i_lpcfp_host.got_q = {};
  endtask : settle
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge CLOCK);
    bad_count++;
    conclude();
  end
  initial begin
    RST        = 1'b1;
    temp       = {rnd(), rnd()};
    TEMP_SENSE = temp;
    repeat (5) @(negedge CLOCK);
    RST = 1'b0;
    @(negedge CLOCK);
    note(tx_valid === 1'b0, "idle response side");
    settle();
    prm = {};
    run(TYPE_LOCAL_CMD, 8'h17, CMD_TEMP_QUERY, 8'h00);
    settle();
    // Label lengths 1..4 accepted, 5 refused; each set followed at once by a query
    for (int n = 1; n <= 5; n++) begin
      prm = {};
      repeat (n) prm.push_back(rnd());
      run(TYPE_LOCAL_CMD, rnd() | 8'h01, CMD_NODE_LABEL, 8'h00);
      prm = {};
      run(TYPE_LOCAL_CMD, rnd() | 8'h01, CMD_NODE_LABEL, 8'h00);
      settle();
    end
    i_lpcfp_host.slow = 1'b1;
    for (int v = 0; v < 5; v++) begin
      prm = {};
      if (v < 3) prm.push_back(8'(v));
      if (v == 3) prm = {8'h01, 8'h00};
      run(TYPE_LOCAL_CMD, rnd() | 8'h01, CMD_ESCAPE_OPT, 8'h00);
    end
    settle();
    prm = {8'h01};
    run(TYPE_LOCAL_CMD, 8'h42, CMD_TEMP_QUERY, 8'h00);
    run(TYPE_LOCAL_CMD, 8'h43, 16'h5858, 8'h00);
    settle();
    i_lpcfp_host.slow = 1'b0;
    prm = {8'h00};
    run(TYPE_LOCAL_CMD, NO_RESPONSE_ID, CMD_ESCAPE_OPT, 8'h00);
    settle();
    prm = {8'h7e, 8'h41};
    run(TYPE_LOCAL_CMD, 8'h55, CMD_NODE_LABEL, 8'h01);
    run(8'h09, 8'h56, CMD_NODE_LABEL, 8'h00);
    settle();
    run(TYPE_LOCAL_CMD, 8'h57, CMD_NODE_LABEL, 8'h00);
    prm = {};
    run(TYPE_LOCAL_CMD, 8'h58, CMD_NODE_LABEL, 8'h00);
    settle();
    // A frame shorter than its four header bytes is dropped with an error pulse
    prm = {8'h7e, 8'h00, 8'h02, 8'h08, 8'h17, 8'he0};
    foreach (prm[i]) i_lpcfp_host.put_byte(prm[i]);
    i_lpcfp_host.rx_valid = 1'b0;
    err_exp++;
    prm = {};
    // Receiver stalls: the two-entry buffer fills and the request side stops taking bytes
    i_lpcfp_host.hold = 1'b1;
    run(TYPE_LOCAL_CMD, 8'h59, CMD_TEMP_QUERY, 8'h00);
    repeat (30) @(negedge CLOCK);
    note(tx_valid === 1'b1 && rx_ready === 1'b0, "stall hold");
    note(i_lpcfp_host.got_q.size() == 0, "nothing taken in stall");
    i_lpcfp_host.hold = 1'b0;
    settle();
    conclude();
  end
endmodule : lpcfp_parser_tb
`default_nettype wire
